// file: verilog/vrss_regs.vh
// Constants of the start-up and strap sequencer: timing, codes, defaults.
// Assumes a 10 MHz system clock; included by the sequencer only.
`ifndef VRSS_REGS_VH
`define VRSS_REGS_VH
// Clock period in ns
`define VRSS_CLK_NS 100
// Longest initialization time after main reset threshold, in us
`define VRSS_INIT_MAX_US 7600
// Hard limit from main threshold to init done, in cycles
`define VRSS_INIT_LIMIT_CYC ((`VRSS_INIT_MAX_US * 1000) / `VRSS_CLK_NS)
// Init length used: copy time and two transition cycles come off the
// limit, so a copy still running at the main threshold cannot overrun
`define VRSS_INIT_CYC (`VRSS_INIT_LIMIT_CYC - `VRSS_NVM_WORDS - 2)
// Longest power-good delay after ramp done, in ns
`define VRSS_PG_MAX_NS 5000
`define VRSS_PG_CYC (`VRSS_PG_MAX_NS / `VRSS_CLK_NS)
// Configuration copy length in cycles
`define VRSS_NVM_WORDS 68
// Bus address table, 7-bit form
`define VRSS_ADDR0 7'h20
`define VRSS_ADDR1 7'h21
`define VRSS_ADDR2 7'h22
`define VRSS_ADDR3 7'h23
// Telemetry scale: mV per LSB, offset in degrees
`define VRSS_VOUT_LSB_MV 5
`define VRSS_TEMP_MIN -40
`define VRSS_TEMP_MAX 150
// Register offsets (plain port)
`define VRSS_REG_STATUS 4'h0
`define VRSS_REG_MASK 4'h1
`define VRSS_REG_STRAP 4'h2
`define VRSS_REG_CONFIG 4'h3
`define VRSS_REG_TELEM_V 4'h4
`define VRSS_REG_TELEM_T 4'h5
// Status bit positions
`define VRSS_ST_SUPPLY_UNDERVOLTAGE_LOCKOUT 0
`define VRSS_ST_INIT_DONE 1
`define VRSS_ST_PG_UP 2
`define VRSS_ST_FAULT 3
`define VRSS_ST_BUS_REJ 4
`define VRSS_ST_W 5
// Reset values
`define VRSS_MASK_RST 5'h0_0
`define VRSS_CONFIG_RST 8'h0_0
`endif

// file: verilog/vrss_sequencer.v
// Start-up, strap latch and power-good sequencing of a three-rail regulator.
// Assumes supply flags and straps are synchronous digital levels from the
// analog front end, and a simple register port from the management bus.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "vrss_regs.vh"

module vrss_sequencer #(
  parameter NRAIL = 3,
  parameter NPH_A = 4,
  parameter INIT_CYC = `VRSS_INIT_CYC,
  parameter NVM_WORDS = `VRSS_NVM_WORDS,
  parameter PG_CYC = `VRSS_PG_CYC,
  parameter DV_FULL = 8,
  parameter DV_SUPPRESSED = 2
) (
  input wire clock_i,
  input wire sys_rst_i,
  input wire supply_undervoltage_lockout_i,
  input wire nvm_load_supply_threshold_i,
  input wire main_por_threshold_i,
  input wire power_enable_in_i,
  input wire [NPH_A-1:0] phase_sense_positive_in_i,
  input wire rail_b_first_phase_sense_pos_i,
  input wire rail_c_first_phase_sense_pos_i,
  input wire [1:0] addr_strap_band_i,
  input wire noise_suppress_enable_pin_i,
  input wire [NRAIL-1:0] rail_in_tolerance_i,
  input wire [NRAIL-1:0] rail_shutdown_fault_i,
  input wire [9:0] vid_target_i,
  input wire vid_target_load_i,
  input wire [9:0] adc_vout_mv_div5_i,
  input wire [9:0] adc_temp_raw_i,
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [7:0] reg_rdata_o,
  output reg irq_o,
  output reg [NRAIL-1:0] high_side_on_o,
  output reg [NRAIL-1:0] low_side_on_o,
  output reg [NRAIL-1:0] rail_power_good_out_o,
  output reg power_good_out_o,
  output reg nvm_copy_active_o,
  output reg [6:0] bus_address_o,
  output reg [2:0] max_phases_a_o,
  output reg [NRAIL-1:0] rail_enabled_o,
  output reg [9:0] ref_code_o,
  output reg [9:0] vout_telemetry_o,
  output reg [9:0] temp_telemetry_o
);

  // One-hot states
  localparam S_OFF = 6'b00_0001;
  localparam S_NVM = 6'b00_0010;
  localparam S_INIT = 6'b00_0100;
  localparam S_IDLE = 6'b00_1000;
  localparam S_RAMP = 6'b01_0000;
  localparam S_RUN = 6'b10_0000;

  reg [5:0] state;
  reg [5:0] next_state;
  reg [22:0] count;
  reg [7:0] pg_count;
  reg [9:0] ramp_target;
  reg [`VRSS_ST_W-1:0] status;
  reg [`VRSS_ST_W-1:0] mask;
  reg [7:0] config_reg;
  reg [NRAIL-1:0] rail_pg_q;
  reg [`VRSS_ST_W-1:0] events;
  reg init_done;
  wire ctrl_enable;
  wire ramp_done;

  // Band code to 7-bit address, used at latch time
  function [6:0] addr_of_band;
    input [1:0] band;
    begin
      case (band)
        2'd0: addr_of_band = `VRSS_ADDR0;
        2'd1: addr_of_band = `VRSS_ADDR1;
        2'd2: addr_of_band = `VRSS_ADDR2;
        default: addr_of_band = `VRSS_ADDR3;
      endcase
    end
  endfunction

  // Lowest high sense pin x gives x phases; none high gives all
  function [2:0] phase_limit;
    input [NPH_A-1:0] sense;
    integer k;
    begin
      phase_limit = NPH_A[2:0];
      for (k = NPH_A - 1; k >= 0; k = k - 1) begin
        if (sense[k]) begin
          phase_limit = k[2:0];
        end
      end
    end
  endfunction

  // Controller runs only with reset flag up and enable high
  assign ctrl_enable = main_por_threshold_i && power_enable_in_i &&
                       !supply_undervoltage_lockout_i;
  assign ramp_done = (ref_code_o == ramp_target);

  // Next state
  always @* begin
    next_state = state;
    case (state)
      S_OFF: begin
        if (nvm_load_supply_threshold_i) begin
          next_state = S_NVM;
        end
      end
      S_NVM: begin
        if (main_por_threshold_i && count >= NVM_WORDS - 1) begin
          next_state = S_INIT;
        end
      end
      S_INIT: begin
        if (count >= INIT_CYC - 1) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (ctrl_enable && (rail_enabled_o != {NRAIL{1'b0}})) begin
          next_state = S_RAMP;
        end
      end
      S_RAMP: begin
        if (!ctrl_enable) begin
          next_state = S_IDLE;
        end else if (ramp_done) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (!ctrl_enable) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_OFF;
    endcase
    // Undervoltage overrides everything
    if (supply_undervoltage_lockout_i) begin
      next_state = S_OFF;
    end
  end

  // State register and phase counter
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= S_OFF;
      count <= 23'h00_0000;
      init_done <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        count <= 23'h00_0000;
      end else begin
        count <= count + 23'h00_0001;
      end
      if (next_state == S_IDLE && state == S_INIT) begin
        init_done <= 1'b1;
      end else if (next_state == S_OFF) begin
        init_done <= 1'b0;
      end
    end
  end

  // Straps sampled only while initializing, held afterwards
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      bus_address_o <= `VRSS_ADDR0;
      max_phases_a_o <= 3'h0;
      rail_enabled_o <= {NRAIL{1'b0}};
    end else if (state == S_INIT && count == 23'h00_0000) begin
      bus_address_o <= addr_of_band(addr_strap_band_i);
      max_phases_a_o <= phase_limit(phase_sense_positive_in_i);
      rail_enabled_o[0] <= !phase_sense_positive_in_i[0];
      rail_enabled_o[1] <= !rail_b_first_phase_sense_pos_i;
      rail_enabled_o[2] <= !rail_c_first_phase_sense_pos_i;
    end
  end

  // Reference ramp; step size shrinks on downward moves when suppressed
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ref_code_o <= 10'h000;
      ramp_target <= 10'h000;
    end else if (state == S_OFF || state == S_NVM || state == S_INIT ||
                 state == S_IDLE) begin
      ref_code_o <= 10'h000;
      ramp_target <= {2'b00, config_reg};
    end else begin
      if (vid_target_load_i && state == S_RUN) begin
        ramp_target <= vid_target_i;
      end
      if (ref_code_o < ramp_target) begin
        if (ramp_target - ref_code_o > DV_FULL[9:0]) begin
          ref_code_o <= ref_code_o + DV_FULL[9:0];
        end else begin
          ref_code_o <= ramp_target;
        end
      end else if (ref_code_o > ramp_target) begin
        if (noise_suppress_enable_pin_i &&
            ref_code_o - ramp_target > DV_SUPPRESSED[9:0]) begin
          ref_code_o <= ref_code_o - DV_SUPPRESSED[9:0];
        end else if (ref_code_o - ramp_target > DV_FULL[9:0]) begin
          ref_code_o <= ref_code_o - DV_FULL[9:0];
        end else begin
          ref_code_o <= ramp_target;
        end
      end
    end
  end

  // Power-good delay counter, well inside the 5 us limit
  always @(posedge clock_i) begin
    if (sys_rst_i || state != S_RUN) begin
      pg_count <= 8'h00;
    end else if (pg_count < PG_CYC[7:0]) begin
      pg_count <= pg_count + 8'h01;
    end
  end

  // Switch controls and power-good outputs
  genvar g;
  generate
    for (g = 0; g < NRAIL; g = g + 1) begin : g_rail
      always @(posedge clock_i) begin
        if (sys_rst_i) begin
          high_side_on_o[g] <= 1'b0;
          low_side_on_o[g] <= 1'b0;
          rail_power_good_out_o[g] <= 1'b0;
        end else begin
          // Both switches off outside ramp and run
          high_side_on_o[g] <= (state == S_RAMP || state == S_RUN) &&
            rail_enabled_o[g] && !rail_shutdown_fault_i[g];
          low_side_on_o[g] <= (state == S_RAMP || state == S_RUN) &&
            rail_enabled_o[g] && !rail_shutdown_fault_i[g];
          rail_power_good_out_o[g] <= state == S_RUN &&
            rail_enabled_o[g] && rail_in_tolerance_i[g] &&
            !rail_shutdown_fault_i[g] && pg_count >= 8'h01;
        end
      end
    end
  endgenerate

  // Combined power-good: every enabled rail is good
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      power_good_out_o <= 1'b0;
      nvm_copy_active_o <= 1'b0;
    end else begin
      power_good_out_o <= state == S_RUN && pg_count >= 8'h01 &&
        ((rail_in_tolerance_i & ~rail_shutdown_fault_i) | ~rail_enabled_o)
        == {NRAIL{1'b1}};
      nvm_copy_active_o <= (state == S_NVM);
    end
  end

  // Telemetry: volts in 5 mV steps, degrees offset by -40 then clamped
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      vout_telemetry_o <= 10'h000;
      temp_telemetry_o <= 10'h000;
    end else begin
      vout_telemetry_o <= adc_vout_mv_div5_i;
      if (adc_temp_raw_i > 10'd190) begin
        temp_telemetry_o <= 10'd190;
      end else begin
        temp_telemetry_o <= adc_temp_raw_i;
      end
    end
  end

  // Event pulses for the sticky status
  always @* begin
    events = {`VRSS_ST_W{1'b0}};
    events[`VRSS_ST_SUPPLY_UNDERVOLTAGE_LOCKOUT] = supply_undervoltage_lockout_i;
    events[`VRSS_ST_INIT_DONE] = (state == S_INIT && next_state == S_IDLE);
    events[`VRSS_ST_PG_UP] = power_good_out_o && !rail_pg_q[0];
    events[`VRSS_ST_FAULT] = |rail_shutdown_fault_i;
    events[`VRSS_ST_BUS_REJ] = reg_write_i && !init_done &&
      reg_addr_i == `VRSS_REG_CONFIG;
  end

  // Registers; set beats write-one-to-clear; config locked until init done
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      status <= {`VRSS_ST_W{1'b0}};
      mask <= `VRSS_MASK_RST;
      config_reg <= `VRSS_CONFIG_RST;
      rail_pg_q <= {NRAIL{1'b0}};
      reg_rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      rail_pg_q <= {{(NRAIL-1){1'b0}}, power_good_out_o};
      if (reg_write_i && reg_addr_i == `VRSS_REG_STATUS) begin
        status <= (status & ~reg_wdata_i[`VRSS_ST_W-1:0]) | events;
      end else begin
        status <= status | events;
      end
      if (reg_write_i && reg_addr_i == `VRSS_REG_MASK) begin
        mask <= reg_wdata_i[`VRSS_ST_W-1:0];
      end
      if (reg_write_i && reg_addr_i == `VRSS_REG_CONFIG && init_done) begin
        config_reg <= reg_wdata_i;
      end
      irq_o <= |(status & mask);
      reg_rdata_o <= 8'h00;
      if (reg_read_i) begin
        case (reg_addr_i)
          `VRSS_REG_STATUS: reg_rdata_o <= {3'b000, status};
          `VRSS_REG_MASK: reg_rdata_o <= {3'b000, mask};
          `VRSS_REG_STRAP: reg_rdata_o <= {init_done, bus_address_o};
          `VRSS_REG_CONFIG: reg_rdata_o <= config_reg;
          `VRSS_REG_TELEM_V: reg_rdata_o <= vout_telemetry_o[9:2];
          `VRSS_REG_TELEM_T: reg_rdata_o <= temp_telemetry_o[7:0];
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule // vrss_sequencer

// file: bench/vrss_checker_properties.sv
// Checker of start-up, strap and shutdown behaviour at the sequencer ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
module vrss_checker #(
  parameter NRAIL = 3
) (
  input wire clock_i,
  input wire sys_rst_i,
  input wire supply_undervoltage_lockout_i,
  input wire nvm_load_supply_threshold_i,
  input wire power_enable_in_i,
  input wire [NRAIL-1:0] rail_shutdown_fault_i,
  input wire [9:0] adc_vout_mv_div5_i,
  input wire [NRAIL-1:0] high_side_on_o,
  input wire [NRAIL-1:0] low_side_on_o,
  input wire [NRAIL-1:0] rail_power_good_out_o,
  input wire power_good_out_o,
  input wire nvm_copy_active_o,
  input wire [6:0] bus_address_o,
  input wire [2:0] max_phases_a_o,
  input wire [NRAIL-1:0] rail_enabled_o,
  input wire [9:0] vout_telemetry_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Off state one cycle on, switches dark the cycle after
  uv_shutdown_a: assert property (
    supply_undervoltage_lockout_i |-> ##2 (high_side_on_o == '0 &&
    low_side_on_o == '0)) else $error("switches on under undervoltage");
  nvm_copy_start_a: assert property (
    $rose(nvm_load_supply_threshold_i) && !supply_undervoltage_lockout_i
    |-> ##[1:2] nvm_copy_active_o) else $error("config copy not started");
  init_quiet_a: assert property (
    nvm_copy_active_o |-> !power_good_out_o && high_side_on_o == '0)
    else $error("output active before init done");
  pg_enable_a: assert property (
    $rose(power_good_out_o) |-> $past(power_enable_in_i))
    else $error("power good without enable");
  // Latched straps must not move once the rails are up
  strap_hold_a: assert property (
    power_good_out_o |-> $stable(bus_address_o) && $stable(max_phases_a_o)
    && $stable(rail_enabled_o)) else $error("strap result moved");
  rail_off_a: assert property (
    ((high_side_on_o | low_side_on_o) & ~rail_enabled_o) == '0)
    else $error("disabled rail switching");
  fault_pg_a: assert property (
    rail_shutdown_fault_i[0] |-> ##[1:2] !rail_power_good_out_o[0])
    else $error("rail power good kept on fault");
  vout_code_a: assert property (
    $stable(adc_vout_mv_div5_i) |-> ##1
    vout_telemetry_o == $past(adc_vout_mv_div5_i))
    else $error("voltage telemetry wrong");
endmodule // vrss_checker

bind vrss_sequencer vrss_checker #(.NRAIL(NRAIL)) u_vrss_checker (
  .clock_i, .sys_rst_i, .supply_undervoltage_lockout_i,
  .nvm_load_supply_threshold_i, .power_enable_in_i, .rail_shutdown_fault_i,
  .adc_vout_mv_div5_i, .high_side_on_o, .low_side_on_o,
  .rail_power_good_out_o, .power_good_out_o, .nvm_copy_active_o,
  .bus_address_o, .max_phases_a_o, .rail_enabled_o, .vout_telemetry_o);

// file: bench/vrss_platform.sv
// Platform power sequencer model driving the enable input.
// Assumes supply_ok_i follows the main supply threshold flag.
`timescale 1ns/100ps
module vrss_platform #(
  parameter WAIT = 60
) (
  input wire clock_i,
  input wire supply_ok_i,
  input wire arm_i,
  output reg power_enable_o
);
  reg [15:0] cnt = 16'h0000;
  initial power_enable_o = 1'b0;
  // Hold enable off until well past the init time
  always @(posedge clock_i) begin
    if (!supply_ok_i) cnt <= 16'h0000;
    else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
    power_enable_o <= arm_i && supply_ok_i && cnt > WAIT;
  end
endmodule // vrss_platform

// file: bench/tb.sv
// Self-checking bench of the sequencer with the platform model.
// Assumes a shortened init (50 cycles) and config copy (4 cycles).
`timescale 1ns/100ps
module tb;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, arm = 1'b0;
  logic supply_undervoltage_lockout_i = 1'b0, main_por_threshold_i = 1'b0;
  logic nvm_load_supply_threshold_i = 1'b0, noise_suppress_enable_pin_i = 1'b0;
  logic rail_b_first_phase_sense_pos_i = 1'b0, vid_target_load_i = 1'b0;
  logic rail_c_first_phase_sense_pos_i = 1'b1;
  logic [3:0] phase_sense_positive_in_i = 4'h4, reg_addr_i = 4'h0;
  logic [1:0] addr_strap_band_i = 2'h0;
  logic [2:0] rail_in_tolerance_i = 3'h7, rail_shutdown_fault_i = 3'h0;
  logic [9:0] vid_target_i = 10'h000, adc_vout_mv_div5_i = 10'h123;
  logic [9:0] adc_temp_raw_i = 10'h12C;
  logic [7:0] reg_wdata_i = 8'h00, d;
  logic reg_write_i = 1'b0, reg_read_i = 1'b0, power_enable_in_i;
  wire [7:0] reg_rdata_o;
  wire irq_o, power_good_out_o, nvm_copy_active_o;
  wire [2:0] high_side_on_o, low_side_on_o, rail_power_good_out_o;
  wire [2:0] max_phases_a_o, rail_enabled_o;
  wire [6:0] bus_address_o;
  wire [9:0] ref_code_o, vout_telemetry_o, temp_telemetry_o;
  int err_total = 0, num_checks = 0, cycles = 0;

  vrss_sequencer #(.INIT_CYC(50), .NVM_WORDS(4)) u_vrss_sequencer (
    .clock_i, .sys_rst_i, .supply_undervoltage_lockout_i,
    .nvm_load_supply_threshold_i, .main_por_threshold_i, .power_enable_in_i,
    .phase_sense_positive_in_i, .rail_b_first_phase_sense_pos_i,
    .rail_c_first_phase_sense_pos_i, .addr_strap_band_i,
    .noise_suppress_enable_pin_i, .rail_in_tolerance_i,
    .rail_shutdown_fault_i, .vid_target_i, .vid_target_load_i,
    .adc_vout_mv_div5_i, .adc_temp_raw_i, .reg_addr_i, .reg_wdata_i,
    .reg_write_i, .reg_read_i, .reg_rdata_o, .irq_o, .high_side_on_o,
    .low_side_on_o, .rail_power_good_out_o, .power_good_out_o,
    .nvm_copy_active_o, .bus_address_o, .max_phases_a_o, .rail_enabled_o,
    .ref_code_o, .vout_telemetry_o, .temp_telemetry_o);
  vrss_platform #(.WAIT(60)) u_vrss_platform (.clock_i,
    .supply_ok_i(main_por_threshold_i), .arm_i(arm),
    .power_enable_o(power_enable_in_i));

  // 10 MHz clock
  always #50 clock_i = ~clock_i;

  task cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] want, input string s);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, want, seen);
    end
  endtask
  // One-cycle strobes; read data taken in the cycle after the strobe
  // Write ends one edge later so two writes never drive the strobe twice
  // in one time step
  task wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_write_i <= 1'b1;
    cyc(1);
    reg_write_i <= 1'b0;
    cyc(1);
  endtask
  task rd(input logic [3:0] a);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    cyc(1);
    reg_read_i <= 1'b0;
    cyc(1);
    d = reg_rdata_o;
  endtask
  // Reset, supply ramp, refused early config write, init to idle
  task boot(input logic [1:0] band);
    sys_rst_i <= 1'b1;
    arm <= 1'b0;
    nvm_load_supply_threshold_i <= 1'b0;
    main_por_threshold_i <= 1'b0;
    addr_strap_band_i <= band;
    cyc(3);
    sys_rst_i <= 1'b0;
    nvm_load_supply_threshold_i <= 1'b1;
    cyc(3);
    chk(nvm_copy_active_o, 1'b1, "copy busy");
    main_por_threshold_i <= 1'b1;
    wr(4'h3, 8'h20);
    rd(4'h0);
    chk(d[4], 1'b1, "refused flag");
    cyc(54);
    rd(4'h2);
    chk(d, {1'b1, 7'h20 + band}, "init done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      complete_run;
    end
  end

  initial begin
    for (int b = 0; b < 4; b++) boot(b[1:0]);
    $display("test address bands done");
    phase_sense_positive_in_i <= 4'h0;
    rail_c_first_phase_sense_pos_i <= 1'b0;
    addr_strap_band_i <= 2'h0;
    noise_suppress_enable_pin_i <= 1'b1;
    cyc(3);
    chk(max_phases_a_o, 3'h2, "phase limit");
    chk(rail_enabled_o, 3'h3, "rails on");
    chk(bus_address_o, 7'h23, "address held");
    $display("test straps done");
    wr(4'h1, 8'h1F);
    wr(4'h0, 8'h1F);
    wr(4'h3, 8'h20);
    rd(4'h3);
    chk(d, 8'h20, "config");
    arm <= 1'b1;
    for (int n = 0; n < 200 && power_good_out_o !== 1'b1; n++) cyc(1);
    chk(power_good_out_o, 1'b1, "power good");
    chk(ref_code_o, 10'h020, "ramp target");
    chk(vout_telemetry_o, 10'h123, "vout code");
    chk(temp_telemetry_o, 10'h0BE, "temp clamp");
    // Power-good rise reaches status one edge later, the interrupt one more
    cyc(2);
    chk(irq_o, 1'b1, "irq raised");
    wr(4'h1, 8'h00);
    cyc(2);
    chk(irq_o, 1'b0, "irq masked");
    wr(4'h1, 8'h1F);
    wr(4'h0, 8'h1F);
    cyc(2);
    chk(irq_o, 1'b0, "irq cleared");
    rd(4'hF);
    chk(d, 8'h00, "unmapped read");
    // Lower target in run: suppressed pin gives small downward steps
    vid_target_i <= 10'h018;
    vid_target_load_i <= 1'b1;
    cyc(1);
    vid_target_load_i <= 1'b0;
    cyc(2);
    chk(ref_code_o, 10'h01E, "downward step");
    $display("test ramp done");
    rail_shutdown_fault_i <= 3'h1;
    rail_in_tolerance_i <= 3'h6;
    cyc(3);
    chk(rail_power_good_out_o[0], 1'b0, "rail fault pg");
    rail_shutdown_fault_i <= 3'h0;
    supply_undervoltage_lockout_i <= 1'b1;
    cyc(3);
    chk({high_side_on_o, low_side_on_o}, 6'h00, "switches");
    chk(power_good_out_o, 1'b0, "pg on uv");
    $display("test faults done");
    complete_run;
  end
endmodule // tb
